/* File: shared/crbf_pkg.sv */
package crbf_pkg;

	localparam int CH_N        = 8;
	localparam int BQ_N        = 5;
	localparam int SLOT_N      = 5;
	localparam int STAGE_BYTES = 15;
	localparam int FIFO_DEPTH  = 8;
	localparam int FRAC_SHIFT  = 23;

	localparam logic [7:0] REG_BASE    = 8'h1c;
	localparam logic [7:0] REG_STAGE0  = 8'h1d;
	localparam logic [7:0] REG_STAGE14 = 8'h2b;
	localparam logic [7:0] REG_WCTRL   = 8'h2c;
	localparam int         WCTRL_SINGLE = 0;
	localparam int         WCTRL_SET    = 1;

	localparam logic [7:0] RAM_BQ_END    = 8'hc8;
	localparam logic [7:0] RAM_PRESCALE  = 8'hc8;
	localparam logic [7:0] RAM_MIXSCALE  = 8'hd0;
	localparam logic [7:0] RAM_POSTSCALE = 8'hd8;
	localparam logic [7:0] RAM_LAST      = 8'hdf;

	localparam logic [23:0] DEF_B0_HALF = 24'h3fffff;
	localparam logic [23:0] DEF_ZERO    = 24'h000000;
	localparam logic [23:0] DEF_SCALE   = 24'h800000;

	localparam logic [2:0] SLOT_B2 = 3'h0;
	localparam logic [2:0] SLOT_B0 = 3'h1;
	localparam logic [2:0] SLOT_A2 = 3'h2;
	localparam logic [2:0] SLOT_A1 = 3'h3;
	localparam logic [2:0] SLOT_B1 = 3'h4;
	localparam logic [2:0] MIX_CH  = 3'h5;
	localparam logic [2:0] MIX_LAST = 3'h7;

	typedef struct packed {
		logic [2:0]         ch;
		logic signed [23:0] data;
	} crbf_sample_type;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} crbf_reg_req_type;

	typedef enum logic [3:0] {
		ST_INIT, ST_IDLE, ST_COMMIT, ST_FETCH, ST_MIX, ST_PRE, ST_BQ, ST_POST
	} crbf_engine_state_type;

endpackage : crbf_pkg

/* File: src/crbf_fifo.sv */
`timescale 1ns/1ps
module crbf_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 8
) (
	input  logic             mclk_i,
	input  logic             sys_rst_i,
	input  logic             ce_i,
	input  logic             in_valid_i,
	output logic             in_ready_o,
	input  logic [WIDTH-1:0] in_data_i,
	output logic             out_valid_o,
	input  logic             out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] count;
	} crbf_fifo_state_type;

	crbf_fifo_state_type q, d;
	logic [WIDTH-1:0]    mem [DEPTH];
	logic                push;
	logic                pop;

	// Ready and valid drop while the clock enable is low so nothing is taken in a frozen cycle.
	assign in_ready_o  = ce_i && (q.count != CW'(DEPTH));
	assign out_valid_o = ce_i && (q.count != '0);
	assign out_data_o  = mem[q.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		d = q;
		if (push) begin
			d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
		end
		if (pop) begin
			d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
		end
		d.count = q.count + CW'(push) - CW'(pop);
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
			if (push) begin
				mem[q.wp] <= in_data_i;
			end
		end
	end

endmodule : crbf_fifo

/* File: src/crbf_coef_ram.sv */
`timescale 1ns/1ps
module crbf_coef_ram #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  logic             mclk_i,
	input  logic             sys_rst_i,
	input  logic             ce_i,
	input  logic             we_i,
	input  logic [AW-1:0]    addr_i,
	input  logic [WIDTH-1:0] wdata_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdata_q;

	assign rdata_o = rdata_q;

	// Contents carry no reset; the engine writes every used word after reset instead.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rdata_q <= '0;
		end else if (ce_i) begin
			if (we_i) begin
				mem[addr_i] <= wdata_i;
			end
			rdata_q <= mem[addr_i];
		end
	end

endmodule : crbf_coef_ram

/* File: src/crbf_filter.sv */
`timescale 1ns/1ps
module crbf_filter #(
	parameter int FIFO_WORDS = crbf_pkg::FIFO_DEPTH
) (
	input  logic                       mclk_i,
	input  logic                       sys_rst_i,
	input  logic                       ce_i,
	input  crbf_pkg::crbf_reg_req_type reg_req_i,
	output logic [7:0]                 reg_rdata_o,
	input  logic                       bass_mix_enable_i,
	input  logic                       biquad_link_i,
	input  logic                       postscale_link_i,
	input  logic                       in_valid_i,
	output logic                       in_ready_o,
	input  crbf_pkg::crbf_sample_type  in_sample_i,
	output logic                       out_valid_o,
	output crbf_pkg::crbf_sample_type  out_sample_o
);
	import crbf_pkg::*;

	typedef struct packed {
		crbf_engine_state_type        st;
		logic                         ph;
		logic [2:0]                   ch;
		logic [2:0]                   bq;
		logic [2:0]                   slot;
		logic [2:0]                   idx;
		logic                         set_mode;
		logic signed [55:0]           acc;
		logic signed [27:0]           cur;
		logic signed [23:0]           xin;
		logic                         pend_single;
		logic                         pend_set;
		logic                         fetch_pend;
		logic [7:0]                   base;
		logic [STAGE_BYTES-1:0][7:0]  stage;
		logic [7:0]                   init_addr;
		logic [2:0]                   init_slot;
		logic [7:0]                   rdata;
		crbf_sample_type              out;
		logic                         out_valid;
	} crbf_core_type;

	crbf_core_type      q, d;
	logic signed [23:0] last_in [CH_N];
	logic signed [27:0] hx1 [CH_N*BQ_N];
	logic signed [27:0] hx2 [CH_N*BQ_N];
	logic signed [27:0] hy1 [CH_N*BQ_N];
	logic signed [27:0] hy2 [CH_N*BQ_N];
	logic               ram_we;
	logic [7:0]         ram_addr;
	logic [23:0]        ram_wdata;
	logic [23:0]        ram_q;
	logic               fifo_valid;
	logic               fifo_pop;
	crbf_sample_type    fifo_out;
	logic [2:0]         coef_ch;
	logic [5:0]         hidx;
	logic signed [27:0] mul_b;
	logic signed [51:0] prod;
	logic signed [55:0] term;
	logic signed [55:0] acc_next;
	logic signed [55:0] prod_scaled;
	logic               halved;
	logic               hist_we;
	logic signed [27:0] y_new;

	function automatic logic signed [27:0] sat28(input logic signed [55:0] v);
		if (v[55:27] == {29{v[55]}}) begin
			return v[27:0];
		end
		return v[55] ? {1'b1, 27'h0} : {1'b0, {27{1'b1}}};
	endfunction : sat28

	function automatic logic signed [23:0] sat24(input logic signed [55:0] v);
		if (v[55:23] == {33{v[55]}}) begin
			return v[23:0];
		end
		return v[55] ? {1'b1, 23'h0} : {1'b0, {23{1'b1}}};
	endfunction : sat24

	crbf_fifo #(
		.WIDTH($bits(crbf_sample_type)),
		.DEPTH(FIFO_WORDS)
	) u_fifo (
		.mclk_i     (mclk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.in_valid_i (in_valid_i),
		.in_ready_o (in_ready_o),
		.in_data_i  (in_sample_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o (fifo_out)
	);

	crbf_coef_ram u_ram (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i     (ce_i),
		.we_i     (ram_we),
		.addr_i   (ram_addr),
		.wdata_i  (ram_wdata),
		.rdata_o  (ram_q)
	);

	assign coef_ch = biquad_link_i ? '0 : q.ch;
	assign hidx    = 6'(q.ch * BQ_N + q.bq);
	// RAM holds -a2 and -a1/2, so every term is added; halved slots are doubled here.
	assign halved      = (q.slot == SLOT_B0) || (q.slot == SLOT_A1) || (q.slot == SLOT_B1);
	assign prod        = signed'(ram_q) * mul_b;
	assign term        = (q.st == ST_BQ && halved) ? (56'(prod) <<< 1) : 56'(prod);
	assign acc_next    = q.acc + term;
	assign prod_scaled = 56'(prod) >>> FRAC_SHIFT;

	always_comb begin
		case (q.st)
			ST_MIX:  mul_b = 28'(last_in[q.idx]);
			ST_PRE:  mul_b = signed'({q.xin, 4'h0});
			ST_POST: mul_b = 28'(signed'(q.cur[27:4]));
			ST_BQ: begin
				case (q.slot)
					SLOT_B2: mul_b = hx2[hidx];
					SLOT_B0: mul_b = q.cur;
					SLOT_A2: mul_b = hy2[hidx];
					SLOT_A1: mul_b = hy1[hidx];
					default: mul_b = hx1[hidx];
				endcase
			end
			default: mul_b = '0;
		endcase
	end

	always_comb begin
		d           = q;
		d.out_valid = 1'b0;
		ram_we      = 1'b0;
		ram_addr    = q.base;
		ram_wdata   = DEF_ZERO;
		fifo_pop    = 1'b0;
		hist_we     = 1'b0;
		y_new       = '0;
		unique case (q.st)
			ST_INIT: begin
				ram_we   = 1'b1;
				ram_addr = q.init_addr;
				if (q.init_addr < RAM_BQ_END) begin
					ram_wdata = (q.init_slot == SLOT_B0) ? DEF_B0_HALF : DEF_ZERO;
				end else if (q.init_addr < RAM_MIXSCALE || q.init_addr >= RAM_POSTSCALE) begin
					ram_wdata = DEF_SCALE;
				end
				d.init_slot = (q.init_slot == SLOT_B1) ? SLOT_B2 : q.init_slot + 3'h1;
				d.init_addr = q.init_addr + 8'h01;
				if (q.init_addr == RAM_LAST) begin
					d.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				d.ph  = 1'b0;
				d.idx = '0;
				// Pending writes are served only here, never inside a sample.
				if (q.pend_set) begin
					d.st       = ST_COMMIT;
					d.set_mode = 1'b1;
				end else if (q.pend_single) begin
					d.st       = ST_COMMIT;
					d.set_mode = 1'b0;
				end else if (q.fetch_pend) begin
					d.st = ST_FETCH;
				end else if (fifo_valid) begin
					// One full evaluation per delivered sample; the source sets the rate.
					fifo_pop = 1'b1;
					d.ch     = fifo_out.ch;
					d.xin    = fifo_out.data;
					d.acc    = '0;
					d.st     = (bass_mix_enable_i && fifo_out.ch == MIX_CH) ? ST_MIX : ST_PRE;
				end
			end
			ST_COMMIT: begin
				ram_we    = 1'b1;
				ram_addr  = q.base + 8'(q.idx);
				ram_wdata = {q.stage[3*q.idx], q.stage[3*q.idx+1], q.stage[3*q.idx+2]};
				d.idx     = q.idx + 3'h1;
				if (!q.set_mode || q.idx == SLOT_B1) begin
					d.st = ST_IDLE;
					if (q.set_mode) begin
						d.pend_set = 1'b0;
					end else begin
						d.pend_single = 1'b0;
					end
				end
			end
			ST_FETCH: begin
				ram_addr = q.base;
				d.ph     = ~q.ph;
				if (q.ph) begin
					// A staging write during the fetch cancels it, so the host's bytes survive.
					if (q.fetch_pend) begin
						d.stage[0] = ram_q[23:16];
						d.stage[1] = ram_q[15:8];
						d.stage[2] = ram_q[7:0];
					end
					d.fetch_pend = 1'b0;
					d.st         = ST_IDLE;
				end
			end
			ST_MIX: begin
				ram_addr = RAM_MIXSCALE + 8'(q.idx);
				d.ph     = ~q.ph;
				if (q.ph) begin
					d.acc = q.acc + prod_scaled;
					d.idx = q.idx + 3'h1;
					if (q.idx == MIX_LAST) begin
						d.xin = sat24(q.acc + prod_scaled);
						d.st  = ST_PRE;
					end
				end
			end
			ST_PRE: begin
				ram_addr = RAM_PRESCALE + 8'(q.ch);
				d.ph     = ~q.ph;
				if (q.ph) begin
					d.cur  = sat28(prod_scaled);
					d.acc  = '0;
					d.bq   = '0;
					d.slot = SLOT_B2;
					d.st   = ST_BQ;
				end
			end
			ST_BQ: begin
				ram_addr = 8'(coef_ch * (BQ_N * SLOT_N) + q.bq * SLOT_N + q.slot);
				d.ph     = ~q.ph;
				if (q.ph) begin
					d.acc  = acc_next;
					d.slot = q.slot + 3'h1;
					if (q.slot == SLOT_B1) begin
						// A section ends: its output feeds the next one in the cascade.
						y_new   = sat28(acc_next >>> FRAC_SHIFT);
						hist_we = 1'b1;
						d.cur   = y_new;
						d.acc   = '0;
						d.slot  = SLOT_B2;
						d.bq    = q.bq + 3'h1;
						if (q.bq == 3'(BQ_N - 1)) begin
							d.st = ST_POST;
						end
					end
				end
			end
			ST_POST: begin
				ram_addr = RAM_POSTSCALE + 8'(postscale_link_i ? 3'h0 : q.ch);
				d.ph     = ~q.ph;
				if (q.ph) begin
					d.out.ch    = q.ch;
					d.out.data  = sat24(prod_scaled);
					d.out_valid = 1'b1;
					d.st        = ST_IDLE;
				end
			end
		endcase
		// Host writes come last so a new strobe or address is never lost to a clear.
		if (reg_req_i.wr) begin
			if (reg_req_i.addr == REG_BASE) begin
				d.base       = reg_req_i.wdata;
				d.fetch_pend = 1'b1;
			end else if (reg_req_i.addr >= REG_STAGE0 && reg_req_i.addr <= REG_STAGE14) begin
				d.stage[4'(reg_req_i.addr - REG_STAGE0)] = reg_req_i.wdata;
				// Staging a byte cancels an outstanding fetch so host data is not overwritten.
				d.fetch_pend = 1'b0;
			end else if (reg_req_i.addr == REG_WCTRL) begin
				if (reg_req_i.wdata[WCTRL_SINGLE]) begin
					d.pend_single = 1'b1;
				end
				if (reg_req_i.wdata[WCTRL_SET]) begin
					d.pend_set = 1'b1;
				end
			end
		end
		if (reg_req_i.addr == REG_BASE) begin
			d.rdata = q.base;
		end else if (reg_req_i.addr >= REG_STAGE0 && reg_req_i.addr <= REG_STAGE14) begin
			d.rdata = q.stage[4'(reg_req_i.addr - REG_STAGE0)];
		end else if (reg_req_i.addr == REG_WCTRL) begin
			d.rdata = {6'h00, q.pend_set, q.pend_single};
		end else begin
			d.rdata = 8'h00;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '{st: ST_INIT, default: '0};
		end else if (ce_i) begin
			q <= d;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < CH_N; i++) begin
				last_in[i] <= '0;
			end
			for (int i = 0; i < CH_N * BQ_N; i++) begin
				hx1[i] <= '0;
				hx2[i] <= '0;
				hy1[i] <= '0;
				hy2[i] <= '0;
			end
		end else if (ce_i) begin
			if (fifo_pop) begin
				last_in[fifo_out.ch] <= fifo_out.data;
			end
			if (hist_we) begin
				hx2[hidx] <= hx1[hidx];
				hx1[hidx] <= q.cur;
				hy2[hidx] <= hy1[hidx];
				hy1[hidx] <= y_new;
			end
		end
	end

	assign reg_rdata_o  = q.rdata;
	assign out_valid_o  = q.out_valid;
	assign out_sample_o = q.out;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i || !ce_i);

	ram_write_gate_a: assert property (ram_we |-> (q.st == ST_INIT || q.st == ST_COMMIT))
		else $error("coefficient RAM written during a sample computation");
	set_burst_five_a: assert property ((q.st == ST_IDLE && q.pend_set) |=> ram_we [*5] ##1 !ram_we)
		else $error("set write did not store exactly five words back to back");
	set_addr_offset_a: assert property ((q.st == ST_IDLE && q.pend_set) |=> ram_addr == q.base ##4 ram_addr == q.base + 8'(SLOT_B1))
		else $error("set write addresses are not base plus zero to four");
	single_data_a: assert property ((q.st == ST_IDLE && q.pend_single && !q.pend_set) |=>
		ram_we && ram_wdata == {$past(q.stage[0]), $past(q.stage[1]), $past(q.stage[2])})
		else $error("single write did not store the first staging triplet");
	strobe_clear_a: assert property ($rose(q.pend_single) |-> ##[1:300] !q.pend_single)
		else $error("single write strobe did not clear");
	fetch_bytes_a: assert property ((q.st == ST_FETCH && q.ph && q.fetch_pend && !reg_req_i.wr) |=>
		{q.stage[0], q.stage[1], q.stage[2]} == $past(ram_q))
		else $error("fetched word not presented in staging bytes");
	base_select_a: assert property ((q.st == ST_FETCH || q.st == ST_COMMIT) |-> ram_addr >= q.base)
		else $error("RAM access ignores the base address");
	link_coef_a: assert property ((q.st == ST_BQ && biquad_link_i) |-> ram_addr < 8'(BQ_N * SLOT_N))
		else $error("linked biquad read outside channel 1 coefficients");
	post_link_a: assert property ((q.st == ST_POST && postscale_link_i) |-> ram_addr == RAM_POSTSCALE)
		else $error("linked post-scale not taken from channel 1");
	init_default_a: assert property ((q.st == ST_INIT && q.init_addr < RAM_BQ_END && q.init_slot == SLOT_B0)
		|-> ram_wdata == DEF_B0_HALF)
		else $error("b0 slot default is wrong");
	mix_route_a: assert property ((fifo_pop && bass_mix_enable_i && fifo_out.ch == MIX_CH) |=> q.st == ST_MIX)
		else $error("channel 6 bypassed the scale-and-mix path");

	set_write_c: cover property (q.st == ST_COMMIT && q.set_mode && q.idx == SLOT_B1);
	single_write_c: cover property (q.st == ST_COMMIT && !q.set_mode);
	mix_path_c: cover property (q.st == ST_MIX ##[1:40] q.st == ST_PRE);
	sample_out_c: cover property (q.out_valid);

endmodule : crbf_filter

/* File: testbench/crbf_host_model.sv */
`timescale 1ns/1ps
module crbf_host_model (
	input  logic                       mclk_i,
	input  logic [7:0]                 reg_rdata_i,
	output crbf_pkg::crbf_reg_req_type reg_req_o
);
	import crbf_pkg::*;

	// Idle cycles after each byte write, so the bench can play a slow host.
	int unsigned pace = 0;

	initial reg_req_o = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		reg_req_o <= '{wr: 1'b1, addr: a, wdata: d};
		@(negedge mclk_i);
		reg_req_o.wr <= 1'b0;
		repeat (pace) @(negedge mclk_i);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		reg_req_o.addr <= a;
		@(negedge mclk_i);
		d = reg_rdata_i;
	endtask : rd

	// Words sit MSB first in w; n is 1 for a single write or 5 for a biquad set.
	task automatic word_write(input logic [7:0] base, input logic [119:0] w, input int n);
		wr(REG_BASE, base);
		for (int j = 0; j < 3 * n; j++) begin
			wr(REG_STAGE0 + 8'(j), w[119-8*j -: 8]);
		end
		wr(REG_WCTRL, (n == 5) ? 8'h02 : 8'h01);
		repeat (12) @(negedge mclk_i);
	endtask : word_write

	// The fetch has no done flag, so the host waits well past a running sample.
	task automatic word_read(input logic [7:0] a, output logic [23:0] w);
		logic [7:0] b;
		wr(REG_BASE, a);
		repeat (100) @(negedge mclk_i);
		for (int j = 0; j < 3; j++) begin
			rd(REG_STAGE0 + 8'(j), b);
			w[23-8*j -: 8] = b;
		end
	endtask : word_read
endmodule : crbf_host_model

/* File: testbench/crbf_filter_tb.sv */
`timescale 1ns/1ps
module crbf_filter_tb;
	import crbf_pkg::*;

	localparam logic [7:0]   DEF_ADDR [9] = '{8'h00, 8'h01, 8'h1a, 8'hc7, 8'hc8, 8'hcf, 8'hd0, 8'hd8, 8'hdf};
	localparam logic [23:0]  DEF_VAL [9] = '{DEF_ZERO, DEF_B0_HALF, DEF_B0_HALF, DEF_ZERO, DEF_SCALE,
		DEF_SCALE, DEF_ZERO, DEF_SCALE, DEF_SCALE};
	localparam logic [119:0] SET_WORDS = 120'h1a2b3c_2b3c4d_3c4d5e_4d5e6f_5e6f70;

	logic             mclk_i = 1'b0;
	logic             sys_rst_i = 1'b1;
	logic             ce_i = 1'b1;
	crbf_reg_req_type reg_req;
	logic [7:0]       reg_rdata;
	logic             mix_en = 1'b0;
	logic             bq_link = 1'b0;
	logic             ps_link = 1'b0;
	logic             in_valid = 1'b0;
	logic             in_ready;
	crbf_sample_type  in_sample = '0;
	logic             out_valid;
	crbf_sample_type  out_sample;
	crbf_sample_type  got_q[$];
	logic             full_seen = 1'b0;
	int               n_fail = 0;
	int               samples_checked = 0;
	logic [23:0]      w;
	logic [7:0]       b;

	always #50 mclk_i = ~mclk_i;

	crbf_host_model host (
		.mclk_i      (mclk_i),
		.reg_rdata_i (reg_rdata),
		.reg_req_o   (reg_req)
	);

	crbf_filter #(.FIFO_WORDS(FIFO_DEPTH)) DUT (
		.mclk_i            (mclk_i),
		.sys_rst_i         (sys_rst_i),
		.ce_i              (ce_i),
		.reg_req_i         (reg_req),
		.reg_rdata_o       (reg_rdata),
		.bass_mix_enable_i (mix_en),
		.biquad_link_i     (bq_link),
		.postscale_link_i  (ps_link),
		.in_valid_i        (in_valid),
		.in_ready_o        (in_ready),
		.in_sample_i       (in_sample),
		.out_valid_o       (out_valid),
		.out_sample_o      (out_sample)
	);

	// The result pulse lasts one cycle, so it is caught at the falling edge.
	always @(negedge mclk_i) begin
		if (out_valid === 1'b1)
			got_q.push_back(out_sample);
		if (in_valid === 1'b1 && in_ready === 1'b0)
			full_seen = 1'b1;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic send(input logic [2:0] c, input logic [23:0] d);
		int k;
		@(negedge mclk_i);
		in_sample = '{ch: c, data: d};
		in_valid = 1'b1;
		k = 0;
		while (in_ready !== 1'b1 && k < 2000) begin
			@(negedge mclk_i);
			k++;
		end
		@(negedge mclk_i);
		in_valid = 1'b0;
	endtask : send

	task automatic expect_out(input string what, input logic [2:0] c, input logic [23:0] d);
		int k;
		k = 0;
		while (got_q.size() == 0 && k < 400) begin
			@(negedge mclk_i);
			k++;
		end
		if (got_q.size() == 0)
			chk(what, {5'h00, c, d}, 32'hffffffff);
		else
			chk(what, {5'h00, c, d}, {5'h00, got_q.pop_front()});
	endtask : expect_out

	task automatic set_cfg(input logic bq, input logic ps, input logic mix);
		@(negedge mclk_i);
		bq_link = bq;
		ps_link = ps;
		mix_en = mix;
	endtask : set_cfg

	initial begin
		repeat (12) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		host.rd(REG_BASE, b);
		chk("base after reset", 32'h0, {24'h0, b});
		repeat (240) @(negedge mclk_i);
		for (int i = 0; i < 9; i++) begin
			host.word_read(DEF_ADDR[i], w);
			chk("default word", {8'h00, DEF_VAL[i]}, {8'h00, w});
		end
		// The last biquad of the map, so an overrun would hit the first pre-scale word.
		host.word_write(8'hc3, SET_WORDS, 5);
		host.rd(REG_WCTRL, b);
		chk("set strobe cleared", 32'h0, {24'h0, b});
		for (int i = 0; i < 5; i++) begin
			host.word_read(8'hc3 + 8'(i), w);
			chk("set word", {8'h00, SET_WORDS[119-24*i -: 24]}, {8'h00, w});
		end
		host.word_read(8'hc2, w);
		chk("below set", {8'h00, DEF_ZERO}, {8'h00, w});
		host.word_read(8'hc8, w);
		chk("above set", {8'h00, DEF_SCALE}, {8'h00, w});
		// A b0/2 of one half with negated pre- and post-scale makes channel 1 exact.
		for (int k = 0; k < 5; k++) begin
			host.pace = (k == 2) ? 3 : 0;
			host.word_write(8'(5 * k + 1), {24'h400000, 96'h0}, 1);
		end
		host.pace = 0;
		host.word_write(RAM_POSTSCALE + 8'h02, 120'h0, 1);
		host.rd(REG_WCTRL, b);
		chk("single strobe cleared", 32'h0, {24'h0, b});
		host.word_read(8'h10, w);
		chk("single word", 32'h00400000, {8'h00, w});
		send(3'h0, 24'h123456);
		expect_out("unity chain", 3'h0, 24'h123456);
		set_cfg(1'b1, 1'b0, 1'b0);
		// Channel 4's own default sections would lose the lowest output bit.
		send(3'h3, 24'h123456);
		expect_out("biquad link", 3'h3, 24'h123456);
		set_cfg(1'b1, 1'b1, 1'b0);
		send(3'h2, 24'h123456);
		expect_out("post link", 3'h2, 24'h123456);
		// Only channel 1 is mixed in, at one half; the default sections lose bits below the output.
		host.word_write(RAM_MIXSCALE, {24'h400000, 96'h0}, 1);
		set_cfg(1'b0, 1'b0, 1'b1);
		send(3'h5, 24'h123456);
		expect_out("mix scale", 3'h5, 24'h091a2b);
		set_cfg(1'b0, 1'b0, 1'b0);
		full_seen = 1'b0;
		for (int i = 0; i < 10; i++) begin
			send(3'h0, {4'h0, 8'(i), 12'h000});
		end
		chk("fifo refused", 32'h1, {31'h0, full_seen});
		for (int i = 0; i < 10; i++) begin
			expect_out("fifo order", 3'h0, {4'h0, 8'(i), 12'h000});
		end
		chk("ready when empty", 32'h1, {31'h0, in_ready});
		@(negedge mclk_i);
		ce_i = 1'b0;
		@(negedge mclk_i);
		chk("ready frozen", 32'h0, {31'h0, in_ready});
		ce_i = 1'b1;
		tally_and_finish();
	end

	// The tests need about 3000 cycles; ten times that means a hang.
	initial begin
		repeat (30000) @(posedge mclk_i);
		n_fail++;
		tally_and_finish();
	end
endmodule : crbf_filter_tb
